/* File: design/accel_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ACCEL_DEFS_SVH
`define ACCEL_DEFS_SVH

`define ADDR_MODE_RATE 7'h20
`define ADDR_ON_DEMAND 7'h22
`define ADDR_FILTER_NOISE 7'h25
`define ADDR_TAP_X 7'h30
`define ADDR_TAP_Y 7'h31
`define ADDR_TAP_Z 7'h32
`define ADDR_TAP_TIMING 7'h33
`define ADDR_WAKE_THR 7'h34
`define ADDR_WAKE_DUR 7'h35

`define REG_RESET 8'h00

// mode_rate_control fields
`define MR_RATE_HI 7
`define MR_RATE_LO 4
`define MR_CLASS_HI 3
`define MR_CLASS_LO 2
`define MR_LP_HI 1
`define MR_LP_LO 0

// on_demand_control fields
`define OD_SW_TRIG 0
`define OD_SRC 1
`define OD_ROUTE_FIFO 2
`define OD_ST_HI 7
`define OD_ST_LO 6

// filter_noise_control, wake_threshold, wake_duration fields
`define FN_LOW_NOISE 2
`define WT_SLEEP_ON 6
`define WT_THR_HI 5
`define WT_THR_LO 0
`define WD_STATIONARY 4

// output rate code used while asleep (12.5 Hz)
`define RATE_SLEEP 4'h2
`define RATE_OFF 4'h0

// turn-on delays per low-power level, and the clock period
`define CLK_PERIOD_NS 50
`define TON_LP1_NS 1200000
`define TON_LP2_NS 1700000
`define TON_LP3_NS 2300000
`define TON_LP4_NS 3550000
`define TON_CNT_W 17

`endif

/* File: design/accel_pkg.sv */
// types shared by the mode and power control design
package accel_pkg;

  typedef enum logic [1:0] {
    CLASS_LOW_POWER = 2'b00,
    CLASS_HIGH_PERF = 2'b01,
    CLASS_ON_DEMAND = 2'b10,
    CLASS_RESERVED = 2'b11
  } run_class_e;

  typedef enum logic [0:0] {
    OD_IDLE = 1'b0,
    OD_CONVERT = 1'b1
  } od_state_e;

endpackage : accel_pkg

/* File: design/regbus_if.sv */
// register access signals between the serial port and the register logic
interface regbus_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic [7:0] rdata;

  modport port (output addr, output wdata, output we, output re, input rdata);
  modport regs (input addr, input wdata, input we, input re, output rdata);
endinterface : regbus_if

/* File: design/serial_reg_port.sv */
// four-wire serial slave turning pin frames into register reads and writes
module serial_reg_port (
  input wire logic clk, // device clock
  input wire logic reset, // synchronous, active high
  input wire logic cs_raw_n, // chip select pin, low selects
  input wire logic spc_raw, // serial clock pin
  input wire logic sdi_raw, // serial data in pin
  output logic sdo_q, // serial data out pin value
  output logic sdo_oe_q, // serial data out drive enable
  regbus_if.port bus // register access
);

  logic cs_s1_q, cs_s2_q, spc_s1_q, spc_s2_q, spc_s3_q, sdi_s1_q, sdi_s2_q;
  logic [4:0] bitcnt_q, bitcnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, wdata_q, wdata_d;
  logic [6:0] addr_q, addr_d;
  logic rd_q, rd_d, we_q, we_d, re_q, re_d, load_q, sdo_d, oe_d;
  logic rise, fall;

  // pins pass two flops before any logic; third spc flop gives the edges
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      spc_s1_q <= 1'b1;
      spc_s2_q <= 1'b1;
      spc_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_raw_n;
      cs_s2_q <= cs_s1_q;
      spc_s1_q <= spc_raw;
      spc_s2_q <= spc_s1_q;
      spc_s3_q <= spc_s2_q;
      sdi_s1_q <= sdi_raw;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  assign rise = spc_s2_q & ~spc_s3_q;
  assign fall = ~spc_s2_q & spc_s3_q;

  // frame: command byte (bit 7 read, bits 6:0 address), then one data byte
  always_comb begin
    bitcnt_d = bitcnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rd_d = rd_q;
    we_d = 1'b0;
    re_d = 1'b0;
    sdo_d = sdo_q;
    oe_d = 1'b0;
    if (cs_s2_q) begin
      bitcnt_d = 5'h00;
      rd_d = 1'b0;
    end else begin
      oe_d = rd_q && (bitcnt_q >= 5'h08);
      if (load_q) begin
        tx_d = bus.rdata; // read data is registered, so load two cycles late
      end
      if (rise && bitcnt_q < 5'h10) begin
        sh_d = {sh_q[6:0], sdi_s2_q};
        bitcnt_d = bitcnt_q + 5'h01;
        if (bitcnt_q == 5'h07) begin
          rd_d = sh_q[6];
          addr_d = {sh_q[5:0], sdi_s2_q};
          re_d = sh_q[6];
        end
        if (bitcnt_q == 5'h0f && !rd_q) begin
          wdata_d = {sh_q[6:0], sdi_s2_q};
          we_d = 1'b1;
        end
      end else if (fall && rd_q && bitcnt_q >= 5'h08) begin
        sdo_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
  end

  // frame state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      bitcnt_q <= 5'h00;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 7'h00;
      wdata_q <= 8'h00;
      rd_q <= 1'b0;
      we_q <= 1'b0;
      re_q <= 1'b0;
      load_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      bitcnt_q <= bitcnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rd_q <= rd_d;
      we_q <= we_d;
      re_q <= re_d;
      load_q <= re_q;
      sdo_q <= sdo_d;
      sdo_oe_q <= oe_d;
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.we = we_q;
  assign bus.re = re_q;

endmodule : serial_reg_port

/* File: design/accel_mode_power_control.sv */
// mode, on-demand conversion, self-test, sleep/wake and tap configuration control
`include "accel_defs.svh"

// Summary of operation
// - low_noise bit picks the noise set
// - class and level fields pick the mode
// - class 10 selects single conversion on demand
// - pin edge starts a conversion when source 0
// - software trigger bit, auto-cleared when sample stored
// - power down after the sample, await trigger
// - ready or fifo flag routed to irq one, only in the on-demand class
// - level-dependent turn-on delay before ready flag
// - self-test force field, 00 disables
// - sleep drops rate to 12.5 Hz, wake resumes
// - wake restores prior mode and rate
// - still detection flags sleep, changes nothing
// - nonzero wake threshold enables high-pass; detection also needs the sleep or stationary bit
// - any axis over threshold wakes from sleep
// - tap thresholds, axes, priority, timing programmable
module accel_mode_power_control
  import accel_pkg::*;
#(
  parameter int unsigned TON_LP1_CYC = `TON_LP1_NS / `CLK_PERIOD_NS, // level one turn-on
  parameter int unsigned TON_LP2_CYC = `TON_LP2_NS / `CLK_PERIOD_NS, // level two turn-on
  parameter int unsigned TON_LP3_CYC = `TON_LP3_NS / `CLK_PERIOD_NS, // level three turn-on
  parameter int unsigned TON_LP4_CYC = `TON_LP4_NS / `CLK_PERIOD_NS // level four turn-on
) (
  input wire logic clk, // device clock, 20 MHz
  input wire logic reset, // synchronous, active high
  input wire logic cs_n, // serial chip select, low selects
  input wire logic spc, // serial clock
  input wire logic sdi, // serial data in
  output logic sdo, // serial data out
  output logic sdo_oe, // high while sdo is driven
  input wire logic irq_pin_two_trigger_input_in, // pin two level, trigger clock
  output logic irq_pin_two_trigger_input_out, // pin two drive value
  output logic irq_pin_two_trigger_input_oe, // high while pin two is driven
  output logic irq_pin_one, // interrupt pin one
  input wire logic [2:0] axis_over_wake, // per axis: above wake threshold
  input wire logic inactivity_seen, // datapath: sleep condition met
  input wire logic fifo_flag_in, // fifo flag from the buffer logic
  output logic [3:0] output_rate_q, // rate code in effect
  output logic [1:0] run_class_q, // operating class in effect
  output logic [1:0] power_level_q, // low-power level in effect
  output logic low_noise_q, // reduced-noise set selected
  output logic [1:0] selftest_force_q, // self-test force, 00 off
  output logic converting_q, // analog chain on for a triggered sample
  output logic sample_store_q, // one-cycle pulse: write sample to outputs
  output logic power_down_q, // analog chain powered down
  output logic sleep_state_q, // sleep or stationary condition held
  output logic wake_hpf_en_q, // high-pass enabled for wake path
  output logic sample_available_flag_q // sample ready flag
);

  regbus_if bus ();

  serial_reg_port u_port (
    .clk(clk),
    .reset(reset),
    .cs_raw_n(cs_n),
    .spc_raw(spc),
    .sdi_raw(sdi),
    .sdo_q(sdo),
    .sdo_oe_q(sdo_oe),
    .bus(bus)
  );

  // turn-on count for a low-power level, loaded as the count minus one
  function automatic logic [`TON_CNT_W-1:0] ton_for(input logic [1:0] lvl);
    logic [`TON_CNT_W-1:0] c;
    unique case (lvl)
      2'b00: c = `TON_CNT_W'(TON_LP1_CYC);
      2'b01: c = `TON_CNT_W'(TON_LP2_CYC);
      2'b10: c = `TON_CNT_W'(TON_LP3_CYC);
      2'b11: c = `TON_CNT_W'(TON_LP4_CYC);
    endcase
    return c - `TON_CNT_W'(1);
  endfunction : ton_for

  // register file
  logic [7:0] mode_rate_control_q, mode_rate_control_d;
  logic [7:0] on_demand_control_q, on_demand_control_d;
  logic [7:0] filter_noise_control_q, filter_noise_control_d;
  logic [7:0] tap_x_threshold_q, tap_x_threshold_d;
  logic [7:0] tap_y_threshold_priority_q, tap_y_threshold_priority_d;
  logic [7:0] tap_z_threshold_axes_q, tap_z_threshold_axes_d;
  logic [7:0] tap_timing_q, tap_timing_d;
  logic [7:0] wake_threshold_q, wake_threshold_d;
  logic [7:0] wake_duration_q, wake_duration_d;
  logic [7:0] rdata_q, rdata_d;
  // trigger pin sync chain
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  // conversion sequencer
  od_state_e state_q, state_d;
  logic [`TON_CNT_W-1:0] cnt_q, cnt_d;
  logic sample_available_flag_d, store_d, sleep_d;
  logic od_mode, pin_src, pin_edge, sw_set, start, done, detect_en, rate_drop;

  assign od_mode = run_class_e'(mode_rate_control_q[`MR_CLASS_HI:`MR_CLASS_LO]) == CLASS_ON_DEMAND;
  assign pin_src = ~on_demand_control_q[`OD_SRC];
  // trigger pin is asynchronous; edge taken after two flops only
  assign pin_edge = trig_s2_q & ~trig_s3_q;
  assign detect_en = (wake_threshold_q[`WT_THR_HI:`WT_THR_LO] != 6'h00) &&
                     (wake_threshold_q[`WT_SLEEP_ON] || wake_duration_q[`WD_STATIONARY]);
  // stationary mode only flags; it never touches rate or class
  assign rate_drop = wake_threshold_q[`WT_SLEEP_ON] && !wake_duration_q[`WD_STATIONARY];

  // software trigger is accepted only while idle in on-demand, source 1
  assign sw_set = bus.we && bus.addr == `ADDR_ON_DEMAND && bus.wdata[`OD_SW_TRIG] &&
                  bus.wdata[`OD_SRC] && od_mode && state_q == OD_IDLE;

  // trigger pin synchroniser; the first flop feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= irq_pin_two_trigger_input_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // register writes and registered read data; unmapped reads give zero
  always_comb begin
    mode_rate_control_d = mode_rate_control_q;
    on_demand_control_d = on_demand_control_q;
    filter_noise_control_d = filter_noise_control_q;
    tap_x_threshold_d = tap_x_threshold_q;
    tap_y_threshold_priority_d = tap_y_threshold_priority_q;
    tap_z_threshold_axes_d = tap_z_threshold_axes_q;
    tap_timing_d = tap_timing_q;
    wake_threshold_d = wake_threshold_q;
    wake_duration_d = wake_duration_q;
    rdata_d = rdata_q;
    if (bus.we) begin
      unique case (bus.addr)
        `ADDR_MODE_RATE: mode_rate_control_d = bus.wdata;
        `ADDR_ON_DEMAND: on_demand_control_d[7:1] = bus.wdata[7:1];
        `ADDR_FILTER_NOISE: filter_noise_control_d = bus.wdata;
        `ADDR_TAP_X: tap_x_threshold_d = bus.wdata;
        `ADDR_TAP_Y: tap_y_threshold_priority_d = bus.wdata;
        `ADDR_TAP_Z: tap_z_threshold_axes_d = bus.wdata;
        `ADDR_TAP_TIMING: tap_timing_d = bus.wdata;
        `ADDR_WAKE_THR: wake_threshold_d = bus.wdata;
        `ADDR_WAKE_DUR: wake_duration_d = bus.wdata;
        default: ;
      endcase
    end
    // the trigger bit is owned by hardware: set by an accepted write, cleared at done
    if (sw_set) begin
      on_demand_control_d[`OD_SW_TRIG] = 1'b1;
    end else if (done || !od_mode) begin
      on_demand_control_d[`OD_SW_TRIG] = 1'b0;
    end
    // rdata ready the cycle after re
    if (bus.re) begin
      unique case (bus.addr)
        `ADDR_MODE_RATE: rdata_d = mode_rate_control_q;
        `ADDR_ON_DEMAND: rdata_d = on_demand_control_q;
        `ADDR_FILTER_NOISE: rdata_d = filter_noise_control_q;
        `ADDR_TAP_X: rdata_d = tap_x_threshold_q;
        `ADDR_TAP_Y: rdata_d = tap_y_threshold_priority_q;
        `ADDR_TAP_Z: rdata_d = tap_z_threshold_axes_q;
        `ADDR_TAP_TIMING: rdata_d = tap_timing_q;
        `ADDR_WAKE_THR: rdata_d = wake_threshold_q;
        `ADDR_WAKE_DUR: rdata_d = wake_duration_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_rate_control_q <= `REG_RESET;
      on_demand_control_q <= `REG_RESET;
      filter_noise_control_q <= `REG_RESET;
      tap_x_threshold_q <= `REG_RESET;
      tap_y_threshold_priority_q <= `REG_RESET;
      tap_z_threshold_axes_q <= `REG_RESET;
      tap_timing_q <= `REG_RESET;
      wake_threshold_q <= `REG_RESET;
      wake_duration_q <= `REG_RESET;
      rdata_q <= 8'h00;
    end else begin
      mode_rate_control_q <= mode_rate_control_d;
      on_demand_control_q <= on_demand_control_d;
      filter_noise_control_q <= filter_noise_control_d;
      tap_x_threshold_q <= tap_x_threshold_d;
      tap_y_threshold_priority_q <= tap_y_threshold_priority_d;
      tap_z_threshold_axes_q <= tap_z_threshold_axes_d;
      tap_timing_q <= tap_timing_d;
      wake_threshold_q <= wake_threshold_d;
      wake_duration_q <= wake_duration_d;
      rdata_q <= rdata_d;
    end
  end

  // read data from a flop
  assign bus.rdata = rdata_q;

  // pin edges faster than the turn-on delay are dropped while busy
  assign start = od_mode && state_q == OD_IDLE &&
                 (pin_src ? pin_edge : on_demand_control_q[`OD_SW_TRIG]);
  // zero count ends the wait
  assign done = state_q == OD_CONVERT && cnt_q == '0;

  // on-demand conversion: power up, wait turn-on, store, power down
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sample_available_flag_d = sample_available_flag_q;
    store_d = 1'b0;
    unique case (state_q)
      OD_IDLE: begin
        if (start) begin
          state_d = OD_CONVERT;
          cnt_d = ton_for(mode_rate_control_q[`MR_LP_HI:`MR_LP_LO]);
          sample_available_flag_d = 1'b0;
        end
      end
      OD_CONVERT: begin
        if (!od_mode) begin
          state_d = OD_IDLE;
        end else if (done) begin
          state_d = OD_IDLE;
          sample_available_flag_d = 1'b1;
          store_d = 1'b1;
        end else begin
          cnt_d = cnt_q - `TON_CNT_W'(1);
        end
      end
    endcase
    if (!od_mode && state_q == OD_IDLE) begin
      sample_available_flag_d = 1'b0;
    end
  end

  // sleep tracking; a wake event outranks a fresh sleep indication
  always_comb begin
    sleep_d = sleep_state_q;
    // detection off clears sleep
    if (!detect_en) begin
      sleep_d = 1'b0;
    end else if (|axis_over_wake) begin
      sleep_d = 1'b0;
    end else if (inactivity_seen) begin
      sleep_d = 1'b1;
    end
  end

  // every output registered, from next-state values or the current register fields
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= OD_IDLE;
      cnt_q <= '0;
      sample_available_flag_q <= 1'b0;
      sample_store_q <= 1'b0;
      converting_q <= 1'b0;
      power_down_q <= 1'b1;
      sleep_state_q <= 1'b0;
      wake_hpf_en_q <= 1'b0;
      output_rate_q <= `RATE_OFF;
      run_class_q <= CLASS_LOW_POWER;
      power_level_q <= 2'b00;
      low_noise_q <= 1'b0;
      selftest_force_q <= 2'b00;
      irq_pin_one <= 1'b0;
      irq_pin_two_trigger_input_out <= 1'b0;
      irq_pin_two_trigger_input_oe <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sample_available_flag_q <= sample_available_flag_d;
      sample_store_q <= store_d;
      converting_q <= state_d == OD_CONVERT;
      power_down_q <= od_mode ? state_d == OD_IDLE :
                      mode_rate_control_q[`MR_RATE_HI:`MR_RATE_LO] == `RATE_OFF;
      sleep_state_q <= sleep_d;
      wake_hpf_en_q <= wake_threshold_q[`WT_THR_HI:`WT_THR_LO] != 6'h00;
      // asleep with rate drop: 12.5 Hz at the chosen level; wake restores fields
      output_rate_q <= (sleep_d && rate_drop) ? `RATE_SLEEP :
                       mode_rate_control_q[`MR_RATE_HI:`MR_RATE_LO];
      run_class_q <= (sleep_d && rate_drop) ? CLASS_LOW_POWER :
                     mode_rate_control_q[`MR_CLASS_HI:`MR_CLASS_LO];
      // level kept while asleep
      power_level_q <= mode_rate_control_q[`MR_LP_HI:`MR_LP_LO];
      low_noise_q <= filter_noise_control_q[`FN_LOW_NOISE];
      selftest_force_q <= on_demand_control_q[`OD_ST_HI:`OD_ST_LO];
      irq_pin_one <= od_mode &&
                     (on_demand_control_q[`OD_ROUTE_FIFO] ? fifo_flag_in : sample_available_flag_d);
      // pin two only drives low
      irq_pin_two_trigger_input_out <= 1'b0;
      // pin two becomes an input while it carries the trigger clock
      irq_pin_two_trigger_input_oe <= !(od_mode && pin_src);
    end
  end

endmodule : accel_mode_power_control

/* File: verification/accel_mode_power_control_sva.sv */
// checker for the on-demand conversion, pin two and sleep/wake behaviour at the ports
module accel_mode_power_control_sva (
  input wire logic clk, // device clock
  input wire logic reset, // synchronous, active high
  input wire logic irq_pin_two_trigger_input_out, // pin two drive value
  input wire logic irq_pin_two_trigger_input_oe, // pin two drive enable
  input wire logic irq_pin_one, // interrupt pin one
  input wire logic [2:0] axis_over_wake, // per axis above threshold
  input wire logic [1:0] run_class_q, // class in effect
  input wire logic converting_q, // conversion running
  input wire logic sample_store_q, // sample write pulse
  input wire logic power_down_q, // analog chain off
  input wire logic sleep_state_q, // sleep held
  input wire logic wake_hpf_en_q, // wake high-pass on
  input wire logic sample_available_flag_q // sample ready flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // pin two only ever pulls low, and is released only in the on-demand class
  pin_drive_low_a: assert property (irq_pin_two_trigger_input_oe |->
    !irq_pin_two_trigger_input_out)
    else $error("pin two driven high");
  pin_input_class_a: assert property (!irq_pin_two_trigger_input_oe |->
    (run_class_q == 2'b10 || $past(run_class_q) == 2'b10))
    else $error("pin two released outside on-demand");
  // store pulse lasts one cycle, then ready flag and power-down
  store_pulse_a: assert property (sample_store_q |=> !sample_store_q)
    else $error("store pulse longer than one cycle");
  store_result_a: assert property (sample_store_q |-> ##[0:1]
    (sample_available_flag_q && power_down_q && !converting_q))
    else $error("no flag or power-down after store");
  convert_power_a: assert property (converting_q |-> !power_down_q)
    else $error("powered down while converting");
  convert_min_a: assert property ($rose(converting_q) |-> converting_q [*8])
    else $error("turn-on count too short");
  convert_bound_a: assert property ($rose(converting_q) |-> ##[20:60] sample_store_q)
    else $error("conversion did not end in time");
  idle_irq_quiet_a: assert property ((run_class_q != 2'b10) [*2] |-> !irq_pin_one)
    else $error("pin one active outside on-demand");
  wake_exit_a: assert property ((sleep_state_q && wake_hpf_en_q && |axis_over_wake) |->
    ##[1:3] !sleep_state_q)
    else $error("no wake on axis over threshold");
endmodule : accel_mode_power_control_sva

bind accel_mode_power_control accel_mode_power_control_sva accel_mode_power_control_sva_i (
  .clk(clk), .reset(reset), .irq_pin_one(irq_pin_one), .axis_over_wake(axis_over_wake),
  .irq_pin_two_trigger_input_out(irq_pin_two_trigger_input_out),
  .irq_pin_two_trigger_input_oe(irq_pin_two_trigger_input_oe),
  .run_class_q(run_class_q), .converting_q(converting_q), .sample_store_q(sample_store_q),
  .power_down_q(power_down_q), .sleep_state_q(sleep_state_q), .wake_hpf_en_q(wake_hpf_en_q),
  .sample_available_flag_q(sample_available_flag_q)
);

/* File: verification/spi_host_model.sv */
// host model: four-wire serial master, clock idle high, one register per frame
module spi_host_model (
  input wire logic clk, // paces the host, changes follow its edges
  output logic cs_n, // chip select, low selects
  output logic spc, // serial clock, idle high
  output logic sdi, // data to the device
  input wire logic sdo, // device data out
  input wire logic sdo_oe // device drives sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sdo_line;

  // pull-up on the data out line when the device lets go
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  initial begin
    cs_n = 1'b1;
    spc = 1'b1;
    sdi = 1'b0;
  end

  // phases of 8 clocks keep each spc level long enough for the synchroniser
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [15:0] frame;
    frame = {rd, a, wd};
    q = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      spc <= 1'b0;
      sdi <= frame[i];
      repeat (8) @(posedge clk);
      spc <= 1'b1;
      repeat (8) @(posedge clk);
      if (i < 8) q = {q[6:0], sdo_line};
    end
    cs_n <= 1'b1;
    sdi <= ~sdi; // not held after the frame
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : spi_host_model

/* File: verification/accel_mode_power_control_bench.sv */
// self-checking bench: register rows, on-demand conversions, pin trigger, sleep and wake
module accel_mode_power_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cs_n, spc, sdi, sdo, sdo_oe, pin2, trig_drv, irq2_out, irq2_oe, irq_pin_one;
  logic [2:0] axis_over_wake;
  logic inactivity_seen, fifo_flag_in, low_noise_q, converting_q, sample_store_q, power_down_q;
  logic [3:0] output_rate_q;
  logic [1:0] run_class_q, power_level_q, selftest_force_q;
  logic sleep_state_q, wake_hpf_en_q, sample_available_flag_q;
  logic [7:0] q;
  logic [23:0] rows[10] = '{24'h20_5757, 24'h22_C0C0, 24'h25_0404, 24'h30_1515, 24'h31_A6A6,
    24'h32_E3E3, 24'h33_7C7C, 24'h35_0000, 24'h34_0000, 24'h40_5A00}; // addr, data, readback
  int ton[4] = '{20, 30, 40, 50};
  int n_fail = 0;
  int comparisons = 0;
  int n, extra;

  // pin two: device pulls low when enabled, else the bench clocks it
  assign pin2 = irq2_oe ? irq2_out : trig_drv;

  accel_mode_power_control #(.TON_LP1_CYC(20), .TON_LP2_CYC(30), .TON_LP3_CYC(40),
    .TON_LP4_CYC(50)) accel_mode_power_control_i (
    .clk(clk), .reset(reset), .cs_n(cs_n), .spc(spc), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .irq_pin_two_trigger_input_in(pin2), .irq_pin_two_trigger_input_out(irq2_out),
    .irq_pin_two_trigger_input_oe(irq2_oe), .irq_pin_one(irq_pin_one),
    .axis_over_wake(axis_over_wake), .inactivity_seen(inactivity_seen),
    .fifo_flag_in(fifo_flag_in), .output_rate_q(output_rate_q), .run_class_q(run_class_q),
    .power_level_q(power_level_q), .low_noise_q(low_noise_q),
    .selftest_force_q(selftest_force_q), .converting_q(converting_q),
    .sample_store_q(sample_store_q), .power_down_q(power_down_q),
    .sleep_state_q(sleep_state_q), .wake_hpf_en_q(wake_hpf_en_q),
    .sample_available_flag_q(sample_available_flag_q));

  spi_host_model spi_host_model_i (.clk(clk), .cs_n(cs_n), .spc(spc), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    spi_host_model_i.xfer(1'b0, a, d, dummy);
  endtask : wr

  // cycles from conversion start to the store pulse, both waits bounded
  task automatic measure(output int cnt);
    int w;
    w = 0;
    cnt = 0;
    while (converting_q !== 1'b1 && w < 700) begin
      @(posedge clk);
      w++;
    end
    while (sample_store_q !== 1'b1 && cnt < 300) begin
      @(posedge clk);
      cnt++;
    end
  endtask : measure

  task automatic pulse_pin;
    @(posedge clk) trig_drv <= 1'b1;
    repeat (4) @(posedge clk);
    trig_drv <= 1'b0;
  endtask : pulse_pin

  task automatic inact_then_wake(input logic exp_sleep, input logic [3:0] exp_rate);
    @(posedge clk) inactivity_seen <= 1'b1;
    @(posedge clk) inactivity_seen <= 1'b0;
    repeat (3) @(posedge clk);
    check("sleep", sleep_state_q, exp_sleep);
    check("rate asleep", output_rate_q, exp_rate);
    check("level asleep", power_level_q, 2'h1);
    @(posedge clk) axis_over_wake <= 3'b010;
    @(posedge clk) axis_over_wake <= 3'b000;
    repeat (3) @(posedge clk);
    check("awake", sleep_state_q, 1'b0);
    check("rate restored", output_rate_q, 4'h7);
    check("class restored", run_class_q, 2'b01);
  endtask : inact_then_wake

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the sequence needs about 12500 cycles
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    print_verdict;
  end

  initial begin
    reset = 1'b1;
    trig_drv = 1'b0;
    axis_over_wake = 3'b000;
    inactivity_seen = 1'b0;
    fifo_flag_in = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    check("pd reset", power_down_q, 1'b1);
    check("pin2 oe reset", irq2_oe, 1'b1);
    spi_host_model_i.xfer(1'b1, 7'h20, 8'h00, q);
    check("ctrl reset", q, 8'h00);
    $display("test reset done");
    // rows: write, read back; the unmapped place reads zero
    foreach (rows[i]) begin
      wr(rows[i][22:16], rows[i][15:8]);
      spi_host_model_i.xfer(1'b1, rows[i][22:16], 8'h00, q);
      check("readback", q, rows[i][7:0]);
    end
    check("class", run_class_q, 2'b01);
    check("level", power_level_q, 2'b11);
    check("rate", output_rate_q, 4'h5);
    check("noise", low_noise_q, 1'b1);
    check("selftest", selftest_force_q, 2'b11);
    $display("test rows done");
    for (int s = 0; s < 4; s++) begin
      wr(7'h22, {s[1:0], 6'h00});
      check("selftest field", selftest_force_q, s[1:0]);
    end
    $display("test selftest done");
    // software trigger at every power level
    for (int lv = 0; lv < 4; lv++) begin
      wr(7'h20, {4'h0, 2'b10, lv[1:0]});
      fork
        wr(7'h22, 8'h03);
        measure(n);
      join
      check("turn-on", (n >= ton[lv] && n <= ton[lv] + 3), 1'b1);
      repeat (2) @(posedge clk);
      check("flag", sample_available_flag_q, 1'b1);
      check("pd after", power_down_q, 1'b1);
      check("irq1 flag", irq_pin_one, 1'b1);
      spi_host_model_i.xfer(1'b1, 7'h22, 8'h00, q);
      check("trigger cleared", q, 8'h02);
    end
    $display("test software trigger done");
    // pin trigger with a second edge inside the conversion
    wr(7'h22, 8'h00);
    check("pin2 released", irq2_oe, 1'b0);
    extra = 0;
    fork
      begin
        pulse_pin();
        repeat (10) @(posedge clk);
        pulse_pin(); // too soon: must be ignored
      end
      begin
        measure(n);
        repeat (150) @(posedge clk) extra += sample_store_q;
      end
    join
    check("pin turn-on", (n >= 50 && n <= 53), 1'b1);
    check("one sample", extra, 0);
    repeat (200) @(posedge clk); // spacing beyond turn-on
    fork
      pulse_pin();
      measure(n);
    join
    check("second pin conv", (n >= 50 && n <= 53), 1'b1);
    $display("test pin trigger done");
    // leaving on-demand clears the flag; fifo flag routed to pin one
    wr(7'h20, 8'h75);
    check("flag off", sample_available_flag_q, 1'b0);
    wr(7'h20, 8'h09);
    wr(7'h22, 8'h04);
    @(posedge clk) fifo_flag_in <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq1 fifo", irq_pin_one, 1'b1);
    @(posedge clk) fifo_flag_in <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq1 idle", irq_pin_one, 1'b0);
    $display("test routing done");
    // sleep with rate drop, then stationary only
    wr(7'h20, 8'h75);
    wr(7'h34, 8'h41);
    check("hpf", wake_hpf_en_q, 1'b1);
    inact_then_wake(1'b1, 4'h2);
    wr(7'h35, 8'h10);
    inact_then_wake(1'b1, 4'h7);
    $display("test sleep done");
    print_verdict;
  end
endmodule : accel_mode_power_control_bench
